// file: load_sense_map.svh
// Register offsets, field positions, reset values and settling counts of
// the load sense multiplexer and diagnosis block.
// Assumes the includer uses the values at the widths named below.
`ifndef LOAD_SENSE_MAP_SVH
`define LOAD_SENSE_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------
`define ADDR_DIAG_CTRL   8'h00
`define ADDR_HW_CFG      8'h04
`define ADDR_DIAG_WORD   8'h08
`define ADDR_IRQ_STAT    8'h0C
`define ADDR_IRQ_MASK    8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SEL_MSB          2
`define SEL_LSB          0
`define BYPASS_BIT       3
`define SETTLED_BIT      4
`define THERM_CLR_BIT    0
`define IRQ_OVL_BIT      0
`define IRQ_OT_BIT       1
`define IRQ_W            2

// ----------------------------------------------------------------------
// Select codes and reset values
// ----------------------------------------------------------------------
`define SEL_LAST_CHAN    3'h4
`define SEL_DISABLE      3'h6
`define SEL_STANDBY      3'h7
`define SEL_RESET        3'h6
`define IRQ_MASK_RESET   2'h0
`define HI_CH_COUNT      3

// ----------------------------------------------------------------------
// Settling times in microseconds and their cycle counts at the core rate
// ----------------------------------------------------------------------
`define CLK_MHZ          50
`define T_MUX_US         30
`define T_EN_US          25
`define T_ON_HI_US       300
`define T_ON_LO_US       180
`define CYC_MUX          (`T_MUX_US * `CLK_MHZ)
`define CYC_EN           (`T_EN_US * `CLK_MHZ)
`define CYC_ON_HI        (`T_ON_HI_US * `CLK_MHZ)
`define CYC_ON_LO        (`T_ON_LO_US * `CLK_MHZ)

`endif

// file: load_sense_pkg.sv
// Types shared by the load sense multiplexer and diagnosis modules.
// Assumes nothing of its surroundings.
package load_sense_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef logic [2:0] sense_sel_t;
    typedef logic [15:0] settle_cnt_t;
    typedef enum logic {SETTLE_IDLE, SETTLE_RUN} settle_state_t;

endpackage

// file: fault_if.sv
// Carrier between the diagnosis top and its fault latch bank.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface fault_if #(parameter int NCH = 5);
    logic [NCH-1:0] overcurrent;
    logic [NCH-1:0] overtemp;
    logic           diag_clear;
    logic           thermal_clear;
    logic [NCH-1:0] overload_lat;
    logic [NCH-1:0] thermal_lat;
    logic [NCH-1:0] fault_flag;
    logic [NCH-1:0] new_overload;
    logic [NCH-1:0] new_thermal;

    modport bank (
        input  overcurrent, overtemp, diag_clear, thermal_clear,
        output overload_lat, thermal_lat, fault_flag,
        output new_overload, new_thermal
    );
    modport ctrl (
        output overcurrent, overtemp, diag_clear, thermal_clear,
        input  overload_lat, thermal_lat, fault_flag,
        input  new_overload, new_thermal
    );
endinterface

// file: fault_latch_bank.sv
// Per-channel overload and overtemperature latches with fault flags.
// Assumes the clear strobes are one-cycle pulses in the core domain.
`timescale 1ns/1ps
module fault_latch_bank #(
    parameter int NCH = 5
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Fault carrier
    fault_if.bank    flt
);

    // ------------------------------------------------------------------
    // Latches
    // ------------------------------------------------------------------
    // A fault present in the clearing cycle wins, so no event is lost.
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                flt.overload_lat[g] <= 1'b0;
            end else if (flt.overcurrent[g]) begin
                flt.overload_lat[g] <= 1'b1;
            end else if (flt.diag_clear) begin
                flt.overload_lat[g] <= 1'b0;
            end
        end

        // Only the dedicated command clears this one, never a read.
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                flt.thermal_lat[g] <= 1'b0;
            end else if (flt.overtemp[g]) begin
                flt.thermal_lat[g] <= 1'b1;
            end else if (flt.thermal_clear) begin
                flt.thermal_lat[g] <= 1'b0;
            end
        end

        // Separate storage, one flag reported for either cause.
        assign flt.fault_flag[g] = flt.overload_lat[g] |
                                   flt.thermal_lat[g];
        assign flt.new_overload[g] = flt.overcurrent[g] &
                                     ~flt.overload_lat[g];
        assign flt.new_thermal[g] = flt.overtemp[g] & ~flt.thermal_lat[g];
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_overload_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        flt.diag_clear |=> ((flt.overload_lat & ~$past(flt.overcurrent))
                            == '0))
        else $error("overload latch survived a diagnosis clear");

    a_thermal_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !flt.thermal_clear |=> ((flt.thermal_lat & $past(flt.thermal_lat))
                                == $past(flt.thermal_lat)))
        else $error("thermal latch lost without clear command");

    a_fault_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        1'b1 |=> ((flt.fault_flag & $past(flt.overcurrent | flt.overtemp))
                  == $past(flt.overcurrent | flt.overtemp)))
        else $error("fault flag missing after a fault");

endmodule

// file: sense_router.sv
// Decodes the sense select code into a registered channel route, pin
// enable, standby request and bypass compare result.
// Assumes the select code and fault inputs are in the core domain.
`timescale 1ns/1ps
`include "load_sense_map.svh"
module sense_router #(
    parameter int NCH = 5
) (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    // Control and channel state
    input  wire load_sense_pkg::sense_sel_t sel_i,
    input  wire logic [NCH-1:0]            ch_on_i,
    input  wire logic [NCH-1:0]            blocked_i,
    input  wire logic [NCH-1:0]            vds_above_i,
    // Decoded outputs
    output logic [NCH-1:0]                 route_o,
    output logic                           oe_o,
    output logic                           standby_o,
    output logic                           bypass_o
);

    logic           is_chan;
    logic [NCH-1:0] next_route;
    logic           next_bypass;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // A channel is routed only when it is on, has no live fault and no latched overtemperature.
    always_comb begin
        next_route  = '0;
        next_bypass = 1'b0;
        is_chan     = (sel_i <= `SEL_LAST_CHAN);
        for (int i = 0; i < NCH; i++) begin
            if (is_chan && sel_i == 3'(i)) begin
                next_route[i] = ch_on_i[i] & ~blocked_i[i];
                next_bypass   = vds_above_i[i];
            end
        end
    end

    // Registered so the analog switch controls never glitch.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            route_o   <= '0;
            oe_o      <= 1'b0;
            standby_o <= 1'b0;
            bypass_o  <= 1'b0;
        end else begin
            route_o   <= next_route;
            oe_o      <= |next_route;
            standby_o <= (sel_i == `SEL_STANDBY);
            bypass_o  <= next_bypass;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_disable_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (sel_i == `SEL_DISABLE) |=> (!oe_o && route_o == '0))
        else $error("sense pin driven while disabled");

    a_blocked_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        1'b1 |=> ((route_o & $past(blocked_i | ~ch_on_i)) == '0))
        else $error("faulted or off channel routed");

    a_route_one: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (sel_i <= `SEL_LAST_CHAN) |=>
            (route_o & ~(NCH'(1) << $past(sel_i))) == '0)
        else $error("route does not match select code");

    a_bypass_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (sel_i <= `SEL_LAST_CHAN) |=>
            bypass_o == $past(vds_above_i[sel_i]))
        else $error("bypass result not from selected channel");

    a_standby_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (sel_i == `SEL_STANDBY) |=> (standby_o && !bypass_o))
        else $error("standby decode wrong");

endmodule

// file: load_sense_mux_diag.sv
// Top of the load sense multiplexer and diagnosis block of a five
// channel high-side switch: select register, fault latches, bypass
// monitor result, settling timer and interrupt.
// Assumes all inputs are synchronous to CORE_CLK_I and that the serial
// frame engine pulses DIAG_XMIT_I while a diagnosis word goes out.
`timescale 1ns/1ps
`include "load_sense_map.svh"
module load_sense_mux_diag #(
    parameter int NCH       = 5,
    parameter int ON_HI_CYC = `CYC_ON_HI,
    parameter int ON_LO_CYC = `CYC_ON_LO
) (
    // Clock and reset
    input  wire logic            CORE_CLK_I,
    input  wire logic            RESETN_I,
    // Register port
    input  wire logic [7:0]      ADDR_I,
    input  wire logic [31:0]     WDATA_I,
    input  wire logic            WR_I,
    input  wire logic            RD_I,
    output logic [31:0]          RDATA_O,
    // Channel state from the power stages
    input  wire logic [NCH-1:0]  CH_ON_I,
    input  wire logic [NCH-1:0]  OVERCURRENT_I,
    input  wire logic [NCH-1:0]  OVERTEMP_I,
    input  wire logic [NCH-1:0]  VDS_ABOVE_I,
    // Serial frame engine
    input  wire logic            DIAG_XMIT_I,
    // Sense output pin control
    output logic [NCH-1:0]       SENSE_ROUTE_O,
    output logic                 SENSE_OE_O,
    output logic                 SENSE_STANDBY_O,
    output logic                 SENSE_SETTLED_O,
    // Diagnosis and interrupt
    output logic [NCH-1:0]       CHANNEL_FAULT_FLAG_O,
    output logic                 IRQ_O
);

    // ------------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------------
    localparam load_sense_pkg::settle_cnt_t CYC_MUX   = 16'(`CYC_MUX);
    localparam load_sense_pkg::settle_cnt_t CYC_EN    = 16'(`CYC_EN);
    localparam load_sense_pkg::settle_cnt_t CYC_ON_HI = 16'(ON_HI_CYC);
    localparam load_sense_pkg::settle_cnt_t CYC_ON_LO = 16'(ON_LO_CYC);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    load_sense_pkg::sense_sel_t    sense_select;
    load_sense_pkg::sense_sel_t    next_select;
    load_sense_pkg::settle_state_t settle_state;
    load_sense_pkg::settle_cnt_t   settle_cnt;
    load_sense_pkg::settle_cnt_t   next_load_val;
    logic [`IRQ_W-1:0]             irq_status;
    logic [`IRQ_W-1:0]             irq_mask;
    logic [`IRQ_W-1:0]             irq_event;
    logic [NCH-1:0]                ch_on_q;
    logic [NCH-1:0]                ch_rise;
    logic                          bypass_compare_result;
    logic                          settled;
    logic                          sel_write;
    logic                          sel_change;
    logic                          sel_is_chan;
    logic                          sel_ch_rise;
    logic                          settle_load;
    logic                          diag_read;
    logic                          stat_read;
    logic                          thermal_latch_clear;
    logic [31:0]                   next_rdata;

    fault_if #(.NCH(NCH)) flt ();

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    // Strobes are single cycle, so each decoded term is a pulse.
    assign sel_write   = WR_I && (ADDR_I == `ADDR_DIAG_CTRL);
    assign next_select = WDATA_I[`SEL_MSB:`SEL_LSB];
    assign sel_change  = sel_write && (next_select != sense_select);
    assign diag_read   = RD_I && (ADDR_I == `ADDR_DIAG_WORD);
    assign stat_read   = RD_I && (ADDR_I == `ADDR_IRQ_STAT);
    assign thermal_latch_clear = WR_I && (ADDR_I == `ADDR_HW_CFG) &&
                                 WDATA_I[`THERM_CLR_BIT];

    // The select field steers routing and the bypass monitor at once.
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            sense_select <= `SEL_RESET;
        end else if (sel_write) begin
            sense_select <= next_select;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            irq_mask <= `IRQ_MASK_RESET;
        end else if (WR_I && ADDR_I == `ADDR_IRQ_MASK) begin
            irq_mask <= WDATA_I[`IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Fault latches
    // ------------------------------------------------------------------
    // The frame engine strobe lands between the second and third serial
    // edges; a register read of the diagnosis word counts the same way.
    assign flt.overcurrent   = OVERCURRENT_I;
    assign flt.overtemp      = OVERTEMP_I;
    assign flt.diag_clear    = DIAG_XMIT_I | diag_read;
    assign flt.thermal_clear = thermal_latch_clear;

    fault_latch_bank #(.NCH(NCH)) u_bank (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (RESETN_I),
        .flt     (flt.bank)
    );

    // ------------------------------------------------------------------
    // Sense routing
    // ------------------------------------------------------------------
    sense_router #(.NCH(NCH)) u_router (
        .clk_i       (CORE_CLK_I),
        .rst_n_i     (RESETN_I),
        .sel_i       (sense_select),
        .ch_on_i     (CH_ON_I),
        .blocked_i   (OVERCURRENT_I | OVERTEMP_I | flt.thermal_lat),
        .vds_above_i (VDS_ABOVE_I),
        .route_o     (SENSE_ROUTE_O),
        .oe_o        (SENSE_OE_O),
        .standby_o   (SENSE_STANDBY_O),
        .bypass_o    (bypass_compare_result)
    );

    // ------------------------------------------------------------------
    // Settling timer
    // ------------------------------------------------------------------
    // The settled bit spares the host a blind wait; it does not stall
    // the routing, which follows the select field at once.
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ch_on_q <= '0;
        end else begin
            ch_on_q <= CH_ON_I;
        end
    end

    assign ch_rise     = CH_ON_I & ~ch_on_q;
    assign sel_is_chan = (sense_select <= `SEL_LAST_CHAN);

    // Pick the wait for whichever change just happened.
    always_comb begin
        sel_ch_rise   = 1'b0;
        next_load_val = CYC_EN;
        for (int i = 0; i < NCH; i++) begin
            if (sel_is_chan && sense_select == 3'(i)) begin
                sel_ch_rise = ch_rise[i];
            end
        end
        if (sel_change) begin
            if (next_select > `SEL_LAST_CHAN) begin
                next_load_val = CYC_EN;
            end else if (sense_select == `SEL_DISABLE) begin
                next_load_val = CYC_EN;
            end else begin
                next_load_val = CYC_MUX;
            end
        end else if (sense_select < 3'(`HI_CH_COUNT)) begin
            next_load_val = CYC_ON_HI;
        end else begin
            next_load_val = CYC_ON_LO;
        end
    end

    assign settle_load = sel_change | sel_ch_rise;

    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            settle_state <= load_sense_pkg::SETTLE_IDLE;
            settle_cnt   <= '0;
            settled      <= 1'b1;
        end else if (settle_load) begin
            settle_state <= load_sense_pkg::SETTLE_RUN;
            settle_cnt   <= next_load_val;
            settled      <= 1'b0;
        end else begin
            case (settle_state)
                load_sense_pkg::SETTLE_IDLE: begin
                    settled <= 1'b1;
                end
                load_sense_pkg::SETTLE_RUN: begin
                    if (settle_cnt <= 16'h0001) begin
                        settle_state <= load_sense_pkg::SETTLE_IDLE;
                        settled      <= 1'b1;
                    end else begin
                        settle_cnt <= settle_cnt - 16'h0001;
                    end
                end
                default: begin
                    settle_state <= load_sense_pkg::SETTLE_IDLE;
                end
            endcase
        end
    end

    assign SENSE_SETTLED_O = settled;

    // ------------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------------
    // New events win over the read that clears, so none is dropped.
    assign irq_event[`IRQ_OVL_BIT] = |flt.new_overload;
    assign irq_event[`IRQ_OT_BIT]  = |flt.new_thermal;

    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            irq_status <= '0;
        end else if (stat_read) begin
            irq_status <= irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    assign IRQ_O = |(irq_status & irq_mask);
    assign CHANNEL_FAULT_FLAG_O = flt.fault_flag;

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Read data stand for one cycle only and are zero otherwise.
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (RD_I) begin
            case (ADDR_I)
                `ADDR_DIAG_CTRL: begin
                    next_rdata[`SEL_MSB:`SEL_LSB] = sense_select;
                    next_rdata[`BYPASS_BIT] = bypass_compare_result;
                    next_rdata[`SETTLED_BIT] = settled;
                end
                `ADDR_DIAG_WORD: begin
                    next_rdata[NCH-1:0] = flt.fault_flag;
                end
                `ADDR_IRQ_STAT: begin
                    next_rdata[`IRQ_W-1:0] = irq_status | irq_event;
                end
                `ADDR_IRQ_MASK: begin
                    next_rdata[`IRQ_W-1:0] = irq_mask;
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            RDATA_O <= 32'h0000_0000;
        end else begin
            RDATA_O <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_select_write: assert property (@(posedge CORE_CLK_I)
        disable iff (!RESETN_I)
        sel_write |=> sense_select == $past(next_select))
        else $error("select field not taken");

    a_bypass_read: assert property (@(posedge CORE_CLK_I)
        disable iff (!RESETN_I)
        (RD_I && ADDR_I == `ADDR_DIAG_CTRL) |=>
            RDATA_O[`BYPASS_BIT] == $past(bypass_compare_result))
        else $error("bypass bit not readable");

    a_diag_keeps_ot: assert property (@(posedge CORE_CLK_I)
        disable iff (!RESETN_I)
        (diag_read && !thermal_latch_clear && flt.thermal_lat != '0) |=>
            ((flt.thermal_lat & $past(flt.thermal_lat))
             == $past(flt.thermal_lat)))
        else $error("diagnosis read cleared a thermal latch");

    a_settle_start: assert property (@(posedge CORE_CLK_I)
        disable iff (!RESETN_I)
        sel_change |=> !SENSE_SETTLED_O [*2])
        else $error("settled flag not dropped on select change");

endmodule

// file: load_stage_model.sv
// Power stage model: switch state, faults and drain voltage of 5 channels.
// Assumes the bench drives its requests in the core clock domain.
`timescale 1ns/1ps
module load_stage_model (
    // Clock and requests
    input  wire logic       clk_i,
    input  wire logic [4:0] on_i,
    input  wire logic [4:0] oc_i,
    input  wire logic [4:0] ot_i,
    input  wire logic [4:0] vds_i,
    // Stage state seen by the diagnosis logic
    output logic      [4:0] on_o,
    output logic      [4:0] oc_o,
    output logic      [4:0] ot_o,
    output logic      [4:0] vds_o
);
    // An overheated stage switches itself off while ot_i is high, so it never looks kinder.
    always_ff @(posedge clk_i) begin
        on_o  <= on_i & ~ot_i;
        oc_o  <= oc_i;
        ot_o  <= ot_i;
        vds_o <= vds_i;
    end
endmodule

// file: load_sense_mux_diag_bench.sv
// Bench of the load sense diagnosis top: register tasks and checks.
// Assumes the design files and the stage model are compiled first.
`timescale 1ns/1ps
`include "load_sense_map.svh"
module load_sense_mux_diag_bench;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, xmit = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic [4:0]  on = 5'h1F, oc = 5'h00, ot = 5'h00, vds = 5'h0A;
    logic [4:0]  s_on, s_oc, s_ot, s_vds, route, fault;
    logic        oe, stby, irq, settled;
    int          mismatches = 0, total_checks = 0;

    load_stage_model u_load_stage_model (.clk_i(clk), .on_i(on), .oc_i(oc),
        .ot_i(ot), .vds_i(vds), .on_o(s_on), .oc_o(s_oc), .ot_o(s_ot),
        .vds_o(s_vds));
    // Short turn-on waits keep the run brief.
    load_sense_mux_diag #(.ON_HI_CYC(30), .ON_LO_CYC(20)) u_load_sense_mux_diag
        (.CORE_CLK_I(clk), .RESETN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .CH_ON_I(s_on),
        .OVERCURRENT_I(s_oc), .OVERTEMP_I(s_ot), .VDS_ABOVE_I(s_vds),
        .DIAG_XMIT_I(xmit), .SENSE_ROUTE_O(route), .SENSE_OE_O(oe),
        .SENSE_STANDBY_O(stby), .SENSE_SETTLED_O(settled),
        .CHANNEL_FAULT_FLAG_O(fault), .IRQ_O(irq));

    // Free running 50 MHz core clock.
    initial begin
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Register port tasks and comparison
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Called just after the load edge; settled rises n edges after it.
    task automatic settle_chk(input int n);
        idle(n - 1);
        chk(settled, 1'b0);
        idle(1);
        chk(settled, 1'b1);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Main sequence: decode of every code, faults, clears and interrupt.
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(`ADDR_DIAG_CTRL, v);
        chk({v[5:0], oe, route}, {6'h16, 6'h00});
        for (int c = 0; c < 8; c++) begin
            wr_reg(`ADDR_DIAG_CTRL, 32'(c));
            idle(2);
            chk(stby, c == 7);
            chk(oe, c < 5);
            chk(route, 5'(c < 5) << c);
            rd_reg(`ADDR_DIAG_CTRL, v);
            chk(v[3], (c < 5) ? vds[c] : 1'b0);
            chk(v[2:0], c[2:0]);
        end
        @(posedge clk) on <= 5'h00;
        wr_reg(`ADDR_DIAG_CTRL, 32'h0);
        idle(3);
        chk(oe, 1'b0);
        @(posedge clk) on <= 5'h1F;
        wr_reg(`ADDR_IRQ_MASK, 32'h3);
        wr_reg(`ADDR_DIAG_CTRL, 32'h2);
        oc <= 5'h04;
        idle(3);
        chk({irq, route, fault}, {1'b1, 5'h00, 5'h04});
        @(posedge clk) oc <= 5'h00;
        idle(3);
        chk(fault, 5'h04);
        rd_reg(`ADDR_DIAG_WORD, v);
        idle(1);
        chk({v[4:0], fault}, {5'h04, 5'h00});
        rd_reg(`ADDR_IRQ_STAT, v);
        idle(1);
        chk({v[1:0], irq}, 3'h2);
        // A frame engine pulse clears a latched overload as well.
        @(posedge clk) oc <= 5'h08;
        @(posedge clk) oc <= 5'h00;
        idle(3);
        chk(fault, 5'h08);
        @(posedge clk) xmit <= 1'b1;
        @(posedge clk) xmit <= 1'b0;
        idle(1);
        chk(fault, 5'h00);
        @(posedge clk) ot <= 5'h02;
        idle(3);
        @(posedge clk) ot <= 5'h00;
        rd_reg(`ADDR_DIAG_WORD, v);
        idle(1);
        chk({v[4:0], fault}, {5'h02, 5'h02});
        wr_reg(`ADDR_HW_CFG, 32'h1);
        idle(1);
        chk(fault, 5'h00);
        rd_reg(`ADDR_IRQ_STAT, v);
        chk(v[1:0], 2'h3);
        // Host waits: leave disable, change channel, then turn channel 3 on.
        wr_reg(`ADDR_DIAG_CTRL, 32'h6);
        wr_reg(`ADDR_DIAG_CTRL, 32'h0);
        settle_chk(`CYC_EN);
        wr_reg(`ADDR_DIAG_CTRL, 32'h1);
        settle_chk(`CYC_MUX);
        @(posedge clk) on <= 5'h17;
        wr_reg(`ADDR_DIAG_CTRL, 32'h3);
        @(posedge clk) on <= 5'h1F;
        idle(2);
        settle_chk(20);
        rd_reg(8'h20, v);
        chk(v, 32'h0);
        end_sim();
    end
endmodule
